// File: rtl/pmsc_countdown.sv
/*
  Reloadable countdown used for the watchdog reset delay and the
  oscillator startup delays.
  Assumes len is at least one; start beats clear in the same cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module pmsc_countdown
  import pmsc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic clear,
  input wire logic [PMSC_CNT_W-1:0] len,
  // Status
  output logic busy,
  output logic done
);

  pmsc_cnt_s st_reg;
  pmsc_cnt_s st_next;

  // Done is the last counting cycle, so the owner sees it len cycles after start
  always_comb begin
    st_next = st_reg;
    done = st_reg.busy && (st_reg.remaining == PMSC_CNT_W'(1));
    if (start) begin
      st_next.busy = 1'b1;
      st_next.remaining = len;
    end else if (clear) begin
      st_next = PMSC_CNT_IDLE;
    end else if (st_reg.busy) begin
      st_next.remaining = st_reg.remaining - PMSC_CNT_W'(1);
      if (done) begin
        st_next.busy = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= PMSC_CNT_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy = st_reg.busy;

endmodule // pmsc_countdown
`default_nettype wire

// File: rtl/pmsc_pkg.sv
/*
  Constants, types and register map of the power management control and
  status block: power-on, power-fail and watchdog flags, stop/idle control,
  and ring oscillator startup from stop.
  Assumes an 8-bit special function register port on the core side, a supply
  monitor that reports two comparator levels, and an external watchdog
  interval counter that delivers one timeout tick per interval.
*/
package pmsc_pkg;
// Operation
// - Power-on flag sets on power-up; only a software write of zero clears it.
// - Power-fail interrupt is raised only while its enable bit is one.
// - Power-fail interrupt vectors execution to location 33h.
// - Power-fail flag sets on a power-fail condition and stays until software clears.
// - Writing one to the power-fail flag forces the interrupt if enabled.
// - Watchdog timeout sets the watchdog interrupt flag.
// - With watchdog reset enabled, reset follows 512 clocks after the flag sets.
// - Software write or any reset clears the watchdog interrupt flag.
// - Watchdog reset sets the watchdog reset flag; software clears it.
// - Power-fail reset clears watchdog reset flag; untouched while reset disabled.
// - Reset enable zero stops watchdog resets; the interval counter keeps running.
// - Watchdog interrupt needs its own enable bit, not the reset enable.
// - Software must strobe the restart bit each period or the device resets.
// - The restart strobe bit clears itself after a write of one.
// - Bandgap select zero removes power-fail interrupt and reset during stop.
// - Stop bit halts execution and stops all clocks.
// - Idle bit halts execution while timers and clocks keep running.
// - Ring-mode status is one on ring oscillator, zero on crystal.
// - Ring select set resumes from stop on ring, crystal after 65,536 cycles.
// - Ring select clear holds execution 65,536 crystal cycles after stop.
// - Ring select is cleared only by power-on reset.
// - Power-fail flag sets again at once while supply stays below warning.
// - Hold reset 65536 clocks after power rises, restart on drop, start at 0000h; the power-on hold here lasts 65537 clocks.
// - Power-fail reset cannot be disabled by any control bit; here a bandgap select of zero masks it during stop.

  // Register offsets
  localparam logic [7:0] PMSC_ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] PMSC_ADDR_EXT_IRQ_FLAGS = 8'h91;
  localparam logic [7:0] PMSC_ADDR_WATCHDOG_POWER = 8'hD8;
  localparam logic [7:0] PMSC_ADDR_EXT_IRQ_ENABLE = 8'hE8;

  // Field positions
  localparam int PMSC_WDC_POR = 6;
  localparam int PMSC_WDC_PF_IRQ_EN = 5;
  localparam int PMSC_WDC_PF_FLAG = 4;
  localparam int PMSC_WDC_WD_FLAG = 3;
  localparam int PMSC_WDC_WD_RST_FLAG = 2;
  localparam int PMSC_WDC_WD_RST_EN = 1;
  localparam int PMSC_WDC_RESTART = 0;
  localparam int PMSC_EIE_WD_IRQ_EN = 4;
  localparam int PMSC_EXTENDED_INTERRUPT_FLAGS_RING_MODE = 2;
  localparam int PMSC_EXTENDED_INTERRUPT_FLAGS_RING_SEL = 1;
  localparam int PMSC_EXTENDED_INTERRUPT_FLAGS_BANDGAP = 0;
  localparam int PMSC_POWER_CONTROL_STOP = 1;
  localparam int PMSC_POWER_CONTROL_IDLE = 0;

  // Counts and vectors
  localparam int PMSC_CNT_W = 17;
  localparam int PMSC_WD_RESET_CLOCKS = 512;
  localparam int PMSC_STARTUP_CLOCKS = 65536;
  localparam logic [15:0] PMSC_PF_VECTOR = 16'h0033;
  localparam logic [15:0] PMSC_RESET_VECTOR = 16'h0000;
  localparam logic [7:0] PMSC_READ_NONE = 8'h00;

  // Operating modes, one-hot
  typedef enum logic [4:0] {
    PMSC_M_POR_HOLD = 5'b00001,
    PMSC_M_RUN = 5'b00010,
    PMSC_M_STOP = 5'b00100,
    PMSC_M_XTAL_WAIT = 5'b01000,
    PMSC_M_RING_RUN = 5'b10000
  } pmsc_mode_e;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pmsc_bus_req_s;

  // Supply monitor levels, high while the supply is below the threshold
  typedef struct packed {
    logic below_warn;
    logic below_reset;
  } pmsc_supply_s;

  // Whole state of the main module
  typedef struct packed {
    pmsc_mode_e mode;
    logic por_flag;
    logic pf_irq_en;
    logic pf_flag;
    logic wd_flag;
    logic wd_rst_flag;
    logic wd_rst_en;
    logic [7:0] ext_irq_enable;
    logic [4:0] extended_interrupt_flags_upper;
    logic ring_select;
    logic bandgap_sel;
    logic [5:0] power_control_upper;
    logic idle;
    logic restart_pulse;
    logic wd_reset_pulse;
    logic [7:0] rd_data;
  } pmsc_state_s;

  localparam pmsc_state_s PMSC_POR_STATE = '{
    mode: PMSC_M_POR_HOLD, por_flag: 1'b1, pf_irq_en: 1'b0, pf_flag: 1'b0,
    wd_flag: 1'b0, wd_rst_flag: 1'b0, wd_rst_en: 1'b0, ext_irq_enable: 8'h00,
    extended_interrupt_flags_upper: 5'h00, ring_select: 1'b0, bandgap_sel: 1'b0, power_control_upper: 6'h00,
    idle: 1'b0, restart_pulse: 1'b0, wd_reset_pulse: 1'b0, rd_data: 8'h00};

  // Countdown state
  typedef struct packed {
    logic busy;
    logic [PMSC_CNT_W-1:0] remaining;
  } pmsc_cnt_s;

  localparam pmsc_cnt_s PMSC_CNT_IDLE = '{busy: 1'b0, remaining: '0};

endpackage

// File: rtl/pmsc_power_ctrl.sv
/*
  Power management control and status: flag and enable registers seen by
  the core, reset sequencing after power-on and power-fail, watchdog reset
  delay, stop and idle control, and ring oscillator resume from stop.
  Assumes clk is the crystal clock (counted for startup), rst_n is the
  power-on reset, supply levels and the watchdog tick are synchronous to clk.
*/
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module pmsc_power_ctrl
  import pmsc_pkg::*;
#(
  parameter int unsigned STARTUP_CLOCKS = PMSC_STARTUP_CLOCKS
)
(
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire pmsc_bus_req_s bus_req,
  output logic [7:0] rd_data,
  // Supply monitor and watchdog interval counter
  input wire pmsc_supply_s supply,
  input wire logic wdt_timeout_tick,
  output logic wdt_restart,
  // Wake-up from stop
  input wire logic wake_event,
  // Core control
  output logic cpu_reset,
  output logic [15:0] reset_vector,
  output logic cpu_halt,
  output logic clocks_stopped,
  output logic ring_mode_status,
  output logic bandgap_enable,
  // Interrupt controller
  output logic pf_irq,
  output logic [15:0] pf_irq_vector,
  output logic wd_irq
);

  localparam logic [PMSC_CNT_W-1:0] STARTUP_LEN = PMSC_CNT_W'(STARTUP_CLOCKS);
  localparam logic [PMSC_CNT_W-1:0] WD_LEN = PMSC_CNT_W'(PMSC_WD_RESET_CLOCKS);

  // One-hot register select, shared by the write and read paths
  function automatic logic [3:0] reg_select(input logic [7:0] a);
    logic [3:0] sel;
    sel = 4'h0;
    sel[0] = (a == PMSC_ADDR_WATCHDOG_POWER);
    sel[1] = (a == PMSC_ADDR_EXT_IRQ_ENABLE);
    sel[2] = (a == PMSC_ADDR_EXT_IRQ_FLAGS);
    sel[3] = (a == PMSC_ADDR_POWER_CONTROL);
    return sel;
  endfunction

  pmsc_state_s st_reg;
  pmsc_state_s st_next;

  logic [3:0] wr_sel;
  logic [3:0] rd_sel;
  logic sw_access;
  logic pf_monitor_on;
  logic pf_warn;
  logic pf_reset;
  logic wd_start;
  logic wd_clear;
  logic wd_busy;
  logic wd_done;
  logic su_start;
  logic su_clear;
  logic su_busy;
  logic su_done;
  logic [7:0] watchdog_power_control_view;
  logic [7:0] extended_interrupt_flags_view;
  logic [7:0] power_control_view;
  logic [7:0] rd_mux;
  logic in_ring;

  // Address decode
  assign wr_sel = bus_req.wr ? reg_select(bus_req.addr) : 4'h0;
  assign rd_sel = bus_req.rd ? reg_select(bus_req.addr) : 4'h0;

  // Software only runs in these modes; writes during reset or stop are dropped
  assign sw_access = (st_reg.mode == PMSC_M_RUN) || (st_reg.mode == PMSC_M_RING_RUN);
  assign in_ring = (st_reg.mode == PMSC_M_RING_RUN);

  // Bandgap is dropped in stop unless selected, saving supply current
  assign pf_monitor_on = !((st_reg.mode == PMSC_M_STOP) && !st_reg.bandgap_sel);
  assign pf_warn = supply.below_warn && pf_monitor_on;
  // Nothing but the stop-mode bandgap gate can mask this reset
  assign pf_reset = supply.below_reset && pf_monitor_on;

  // Register views
  assign watchdog_power_control_view = {1'b0, st_reg.por_flag, st_reg.pf_irq_en, st_reg.pf_flag,
                       st_reg.wd_flag, st_reg.wd_rst_flag, st_reg.wd_rst_en,
                       1'b0};
  assign extended_interrupt_flags_view = {st_reg.extended_interrupt_flags_upper, in_ring, st_reg.ring_select,
                      st_reg.bandgap_sel};
  assign power_control_view = {st_reg.power_control_upper, (st_reg.mode == PMSC_M_STOP), st_reg.idle};

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    case (rd_sel)
      4'h1: rd_mux = watchdog_power_control_view;
      4'h2: rd_mux = st_reg.ext_irq_enable;
      4'h4: rd_mux = extended_interrupt_flags_view;
      4'h8: rd_mux = power_control_view;
      default: rd_mux = PMSC_READ_NONE;
    endcase
  end

  // Next-state logic for registers, modes and counter controls
  always_comb begin
    st_next = st_reg;
    wd_start = 1'b0;
    wd_clear = 1'b0;
    su_start = 1'b0;
    su_clear = 1'b0;
    st_next.restart_pulse = 1'b0;
    st_next.wd_reset_pulse = 1'b0;
    st_next.rd_data = rd_mux;

    // Software writes
    if (sw_access) begin
      if (wr_sel[0]) begin
        st_next.por_flag = st_reg.por_flag && bus_req.wdata[PMSC_WDC_POR];
        st_next.pf_irq_en = bus_req.wdata[PMSC_WDC_PF_IRQ_EN];
        st_next.pf_flag = bus_req.wdata[PMSC_WDC_PF_FLAG];
        st_next.wd_flag = bus_req.wdata[PMSC_WDC_WD_FLAG];
        st_next.wd_rst_flag = bus_req.wdata[PMSC_WDC_WD_RST_FLAG];
        st_next.wd_rst_en = bus_req.wdata[PMSC_WDC_WD_RST_EN];
        // Strobe is a pulse only, the bit itself never stores
        st_next.restart_pulse = bus_req.wdata[PMSC_WDC_RESTART];
      end
      if (wr_sel[1]) begin
        st_next.ext_irq_enable = bus_req.wdata;
      end
      if (wr_sel[2]) begin
        st_next.extended_interrupt_flags_upper = bus_req.wdata[7:3];
        st_next.ring_select = bus_req.wdata[PMSC_EXTENDED_INTERRUPT_FLAGS_RING_SEL];
        st_next.bandgap_sel = bus_req.wdata[PMSC_EXTENDED_INTERRUPT_FLAGS_BANDGAP];
      end
      if (wr_sel[3]) begin
        st_next.power_control_upper = bus_req.wdata[7:2];
        st_next.idle = bus_req.wdata[PMSC_POWER_CONTROL_IDLE];
        if (bus_req.wdata[PMSC_POWER_CONTROL_STOP]) begin
          st_next.mode = PMSC_M_STOP;
          st_next.idle = 1'b0;
          su_clear = 1'b1;
        end
      end
    end

    // Hardware sets after the write, so a set in the clearing cycle wins
    if (pf_warn) begin
      st_next.pf_flag = 1'b1;
    end
    if (wdt_timeout_tick && sw_access) begin
      st_next.wd_flag = 1'b1;
    end

    // Any pending request or a wake pin ends idle
    if (st_reg.idle && (pf_irq || wd_irq || wake_event)) begin
      st_next.idle = 1'b0;
    end

    // Watchdog reset delay runs only while the reset is enabled
    if (wdt_timeout_tick && sw_access && st_reg.wd_rst_en) begin
      wd_start = 1'b1;
    end
    // Only a running delay needs clearing
    if ((st_reg.restart_pulse || !st_reg.wd_rst_en) && wd_busy) begin
      wd_clear = 1'b1;
    end

    // Mode sequencing
    case (st_reg.mode)
      PMSC_M_POR_HOLD: begin
        if (!su_busy) begin
          su_start = 1'b1;
        end else if (su_done) begin
          st_next.mode = PMSC_M_RUN;
        end
      end
      PMSC_M_RUN: begin
      end
      PMSC_M_STOP: begin
        if (wake_event) begin
          su_start = 1'b1;
          if (st_reg.ring_select) begin
            st_next.mode = PMSC_M_RING_RUN;
          end else begin
            st_next.mode = PMSC_M_XTAL_WAIT;
          end
        end
      end
      PMSC_M_XTAL_WAIT: begin
        if (su_done) begin
          st_next.mode = PMSC_M_RUN;
        end
      end
      PMSC_M_RING_RUN: begin
        if (su_done && (st_next.mode == PMSC_M_RING_RUN)) begin
          st_next.mode = PMSC_M_RUN;
        end
      end
      default: begin
        st_next.mode = PMSC_M_POR_HOLD;
      end
    endcase

    // Watchdog expiry: one-cycle core reset, cause recorded
    if (wd_done && st_reg.wd_rst_en && !wd_clear) begin
      st_next = PMSC_POR_STATE;
      st_next.mode = PMSC_M_RUN;
      st_next.por_flag = st_reg.por_flag;
      st_next.ring_select = st_reg.ring_select;
      st_next.wd_flag = 1'b0;
      st_next.wd_rst_flag = 1'b1;
      st_next.wd_reset_pulse = 1'b1;
      st_next.rd_data = rd_mux;
      su_start = 1'b0;
      su_clear = 1'b1;
    end

    // Power-fail reset: full hold, startup count restarts each cycle it lasts
    if (pf_reset) begin
      st_next = PMSC_POR_STATE;
      st_next.por_flag = st_reg.por_flag;
      st_next.ring_select = st_reg.ring_select;
      st_next.wd_rst_flag = 1'b0;
      st_next.rd_data = rd_mux;
      su_start = 1'b1;
      su_clear = 1'b0;
      wd_start = 1'b0;
      wd_clear = 1'b1;
    end
  end

  // State register; power-on reset is the only reset that clears ring select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= PMSC_POR_STATE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Watchdog reset delay
  pmsc_countdown u_wd_delay (
    .clk(clk),
    .rst_n(rst_n),
    .start(wd_start),
    .clear(wd_clear),
    .len(WD_LEN),
    .busy(wd_busy),
    .done(wd_done)
  );

  // Power-on and stop-exit oscillator startup count
  pmsc_countdown u_startup (
    .clk(clk),
    .rst_n(rst_n),
    .start(su_start),
    .clear(su_clear),
    .len(STARTUP_LEN),
    .busy(su_busy),
    .done(su_done)
  );

  // Interrupt requests follow flag and enable
  assign pf_irq = st_reg.pf_flag && st_reg.pf_irq_en;
  assign wd_irq = st_reg.wd_flag && st_reg.ext_irq_enable[PMSC_EIE_WD_IRQ_EN];
  assign pf_irq_vector = PMSC_PF_VECTOR;
  assign reset_vector = PMSC_RESET_VECTOR;

  // Core control decodes of the mode register and the other state bits
  assign cpu_reset = (st_reg.mode == PMSC_M_POR_HOLD) || st_reg.wd_reset_pulse;
  assign cpu_halt = st_reg.idle || (st_reg.mode == PMSC_M_STOP)
                    || (st_reg.mode == PMSC_M_XTAL_WAIT);
  assign clocks_stopped = (st_reg.mode == PMSC_M_STOP);
  assign ring_mode_status = in_ring;
  assign bandgap_enable = pf_monitor_on;
  assign wdt_restart = st_reg.restart_pulse;
  assign rd_data = st_reg.rd_data;

endmodule // pmsc_power_ctrl
`default_nettype wire

// File: tb/pmsc_core_model.sv
/* Watchdog interval counter standing beside the core.
   Assumes the bench raises run to ask for one tick. */
`timescale 1ns/100ps
`default_nettype none
module pmsc_core_model #(
  parameter int PERIOD = 64
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Interval counter
  input wire logic run,
  input wire logic wdt_restart,
  output logic tick
);
  logic [15:0] cnt_reg;
  // A restart strobe starts the period over
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= run && !wdt_restart && cnt_reg == 16'(PERIOD - 1);
      if (wdt_restart || !run || cnt_reg == 16'(PERIOD - 1)) cnt_reg <= 16'h0000;
      else cnt_reg <= cnt_reg + 16'h0001;
    end
  end
endmodule // pmsc_core_model
`default_nettype wire

// File: tb/pmsc_power_ctrl_asserts.sv
/* Port checks of pmsc_power_ctrl.
   Assumes one clock domain; bound to the block at the foot of this file. */
`timescale 1ns/100ps
`default_nettype none
module pmsc_power_ctrl_asserts
  import pmsc_pkg::*;
#(
  parameter int unsigned STARTUP_CLOCKS = PMSC_STARTUP_CLOCKS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Block inputs
  input wire pmsc_bus_req_s bus_req,
  input wire pmsc_supply_s supply,
  input wire logic wdt_timeout_tick,
  // Block outputs
  input wire logic wdt_restart,
  input wire logic cpu_reset,
  input wire logic [15:0] reset_vector,
  input wire logic cpu_halt,
  input wire logic clocks_stopped,
  input wire logic ring_mode_status,
  input wire logic bandgap_enable,
  input wire logic pf_irq,
  input wire logic [15:0] pf_irq_vector
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [16:0] ring_reg;
  // Length of the present ring oscillator run
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ring_reg <= '0;
    else if (ring_mode_status) ring_reg <= ring_reg + 17'h00001;
    else ring_reg <= '0;
  end
  // Write accepted while the core runs
  sequence s_wr(logic [7:0] a, int b);
    bus_req.wr && bus_req.addr == a && bus_req.wdata[b] && !cpu_halt && !cpu_reset;
  endsequence
  // Reset rise not caused by the supply monitor
  sequence s_wd_rst;
    $rose(cpu_reset) && !$past(supply.below_reset);
  endsequence
  a_pf_vector: assert property (pf_irq_vector == PMSC_PF_VECTOR)
    else $error("power-fail vector wrong");
  a_reset_vector: assert property ($fell(cpu_reset) |-> reset_vector == 16'h0000)
    else $error("reset vector wrong");
  a_restart_pulse: assert property (s_wr(PMSC_ADDR_WATCHDOG_POWER, PMSC_WDC_RESTART)
    |=> wdt_restart ##1 !wdt_restart) else $error("restart strobe not one pulse");
  a_bandgap_stop: assert property (!bandgap_enable && !cpu_reset |-> clocks_stopped)
    else $error("bandgap off outside stop");
  a_stop_quiet: assert property (clocks_stopped && !bandgap_enable
    |=> !$rose(pf_irq) && !$rose(cpu_reset)) else $error("monitor acted in stop");
  a_wd_delay: assert property (s_wd_rst |-> $past(wdt_timeout_tick, 513))
    else $error("watchdog reset not 512 clocks after flag");
  a_ring_wake: assert property ($rose(ring_mode_status)
    |-> $past(clocks_stopped) && !cpu_halt) else $error("ring resume wrong");
  a_ring_length: assert property ($fell(ring_mode_status) && !cpu_reset
    |-> ring_reg == 17'(STARTUP_CLOCKS)) else $error("ring run length wrong");
endmodule // pmsc_power_ctrl_asserts

bind pmsc_power_ctrl pmsc_power_ctrl_asserts #(.STARTUP_CLOCKS(STARTUP_CLOCKS)) u_chk (
  .clk, .rst_n, .bus_req, .supply, .wdt_timeout_tick, .wdt_restart, .cpu_reset,
  .reset_vector, .cpu_halt, .clocks_stopped, .ring_mode_status, .bandgap_enable,
  .pf_irq, .pf_irq_vector);
`default_nettype wire

// File: tb/tb_top.sv
/* Self-checking bench of pmsc_power_ctrl, startup count cut to 16.
   Assumes the checker is bound in and the core model gives ticks. */
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import pmsc_pkg::*;
;
  localparam int SC = 16;
  localparam logic [7:0] WDC = PMSC_ADDR_WATCHDOG_POWER;
  localparam logic [7:0] EXTENDED_INTERRUPT_ENABLE = PMSC_ADDR_EXT_IRQ_ENABLE;
  localparam logic [7:0] EXF = PMSC_ADDR_EXT_IRQ_FLAGS;
  localparam logic [7:0] PCN = PMSC_ADDR_POWER_CONTROL;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pmsc_bus_req_s req = '0;
  pmsc_supply_s supply = '0;
  logic wake = 1'b0;
  logic run = 1'b0;
  logic tick, wdt_restart, cpu_reset, cpu_halt, clocks_stopped;
  logic ring_mode_status, bandgap_enable, pf_irq, wd_irq;
  logic [7:0] rd_data;
  logic [15:0] reset_vector, pf_irq_vector;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  int n;

  pmsc_power_ctrl #(.STARTUP_CLOCKS(SC)) u_pmsc_power_ctrl (.clk, .rst_n, .bus_req(req),
    .rd_data, .supply, .wdt_timeout_tick(tick), .wdt_restart, .wake_event(wake), .cpu_reset,
    .reset_vector, .cpu_halt, .clocks_stopped, .ring_mode_status, .bandgap_enable, .pf_irq,
    .pf_irq_vector, .wd_irq);
  pmsc_core_model u_pmsc_core_model (.clk, .rst_n, .run, .wdt_restart, .tick);

  // 25 MHz clock
  always #20 clk = ~clk;

  // Cycle ceiling, far above the whole run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic sig(int s);
    case (s)
      0: return cpu_reset;
      1: return cpu_halt;
      2: return ring_mode_status;
      3: return !cpu_reset;
      default: return !tick;
    endcase
  endfunction

  // Edges counted while a level holds, bounded by lim
  task automatic hold(int s, int lim, output int k);
    k = 0;
    while (sig(s) === 1'b1 && k < lim) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask

  task automatic edges(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk("rd_data", 16'(e), 16'(rd_data));
  endtask

  task automatic wake_up();
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    #1;
  endtask

  // Returns one edge after the tick was sampled
  task automatic get_tick();
    @(posedge clk);
    run <= 1'b1;
    #1;
    hold(4, 200, n);
    @(posedge clk);
    run <= 1'b0;
    #1;
  endtask

  task automatic t_power_up();
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    hold(0, 100, n);
    chk("reset_len", 16'(SC + 1), 16'(n));
    chk("reset_vector", 16'h0000, reset_vector);
    rd(WDC, 8'h40);
  endtask

  task automatic t_registers();
    wr(EXTENDED_INTERRUPT_ENABLE, 8'hA5);
    rd(EXTENDED_INTERRUPT_ENABLE, 8'hA5);
    wr(EXF, 8'hFC);
    rd(EXF, 8'hF8);
    wr(PCN, 8'hFC);
    rd(PCN, 8'hFC);
    rd(8'h20, 8'h00);
    wr(EXTENDED_INTERRUPT_ENABLE, 8'h00);
    wr(EXF, 8'h00);
    wr(WDC, 8'h40);
    rd(WDC, 8'h40);
    wr(WDC, 8'h00);
    rd(WDC, 8'h00);
  endtask

  task automatic t_power_fail();
    @(posedge clk);
    supply.below_warn <= 1'b1;
    rd(WDC, 8'h10);
    chk("pf_irq", 16'h0000, 16'(pf_irq));
    wr(WDC, 8'h20);
    rd(WDC, 8'h30);
    chk("pf_irq", 16'h0001, 16'(pf_irq));
    @(posedge clk);
    supply.below_warn <= 1'b0;
    wr(WDC, 8'h20);
    rd(WDC, 8'h20);
    chk("pf_irq", 16'h0000, 16'(pf_irq));
    wr(WDC, 8'h30);
    chk("pf_irq", 16'h0001, 16'(pf_irq));
    chk("pf_irq_vector", 16'h0033, pf_irq_vector);
    wr(WDC, 8'h00);
  endtask

  task automatic t_wd_flag();
    get_tick();
    rd(WDC, 8'h08);
    chk("wd_irq", 16'h0000, 16'(wd_irq));
    wr(EXTENDED_INTERRUPT_ENABLE, 8'h10);
    chk("wd_irq", 16'h0001, 16'(wd_irq));
    wr(WDC, 8'h00);
    chk("wd_irq", 16'h0000, 16'(wd_irq));
  endtask

  task automatic t_wd_reset();
    wr(EXF, 8'h02);
    wr(WDC, 8'h02);
    get_tick();
    hold(3, 1000, n);
    chk("wd_delay", 16'd512, 16'(n));
    edges(1);
    chk("cpu_reset", 16'h0000, 16'(cpu_reset));
    rd(WDC, 8'h04);
    rd(EXTENDED_INTERRUPT_ENABLE, 8'h00);
    rd(EXF, 8'h02);
  endtask

  // Supply reset keeps ring select and drops the watchdog reset flag
  task automatic t_supply_reset();
    @(posedge clk);
    supply.below_reset <= 1'b1;
    edges(3);
    @(posedge clk);
    supply.below_reset <= 1'b0;
    #1;
    hold(0, 100, n);
    chk("supply_reset_len", 16'(SC), 16'(n));
    rd(WDC, 8'h00);
    rd(EXF, 8'h02);
  endtask

  // Strobed in time, then reset disabled: neither may reset the core
  task automatic t_wd_safe();
    for (int i = 0; i < 2; i++) begin
      wr(WDC, i == 0 ? 8'h02 : 8'h00);
      get_tick();
      if (i == 0) wr(WDC, 8'h03);
      hold(3, 600, n);
      chk("no_reset", 16'd600, 16'(n));
      rd(WDC, i == 0 ? 8'h02 : 8'h08);
    end
  endtask

  task automatic t_idle();
    wr(PCN, 8'h01);
    chk("cpu_halt", 16'h0001, 16'(cpu_halt));
    chk("clocks_stopped", 16'h0000, 16'(clocks_stopped));
    wake_up();
    chk("cpu_halt", 16'h0000, 16'(cpu_halt));
  endtask

  // Ring resume with bandgap kept, then crystal resume without it
  task automatic t_stop();
    for (int i = 0; i < 2; i++) begin
      wr(EXF, i == 0 ? 8'h03 : 8'h00);
      wr(PCN, 8'h02);
      chk("clocks_stopped", 16'h0001, 16'(clocks_stopped));
      chk("bandgap_enable", 16'(i == 0), 16'(bandgap_enable));
      // Supply dips in stop on the crystal pass only; without the bandgap the monitor must stay blind
      @(posedge clk);
      supply <= {2{i == 1}};
      edges(3);
      @(posedge clk);
      supply <= '0;
      #1;
      wake_up();
      if (i == 0) begin
        chk("ring_mode", 16'h0001, 16'(ring_mode_status));
        chk("cpu_halt", 16'h0000, 16'(cpu_halt));
        hold(2, 100, n);
        chk("ring_len", 16'(SC), 16'(n));
      end else begin
        hold(1, 100, n);
        chk("xtal_wait", 16'(SC), 16'(n));
        rd(WDC, 8'h08);
      end
      chk("ring_mode", 16'h0000, 16'(ring_mode_status));
    end
  endtask

  // Main sequence
  initial begin
    t_power_up();
    t_registers();
    t_power_fail();
    t_wd_flag();
    t_wd_reset();
    t_supply_reset();
    t_wd_safe();
    t_idle();
    t_stop();
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
